// ==== hdl/dbs_host.sv ====
// Memory controller end with its read-data FIFO
`timescale 1ns/1ps
module dbs_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = dbs_pkg::FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [PW:0]   count;
   } dbs_fifo_state_t;

   dbs_fifo_state_t st_reg;
   dbs_fifo_state_t st_next;
   logic [WIDTH-1:0] store [DEPTH];
   logic push;
   logic pop;

   assign in_ready  = st_reg.count != (PW+1)'(DEPTH);
   assign out_valid = st_reg.count != '0;
   assign push      = ce && in_valid && in_ready;
   assign pop       = ce && out_valid && out_ready;
   assign out_data  = store[st_reg.rd_ptr];

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wr_ptr = (st_reg.wr_ptr == PW'(DEPTH-1)) ? '0 : st_reg.wr_ptr + 1'b1;
      end
      if (pop) begin
         st_next.rd_ptr = (st_reg.rd_ptr == PW'(DEPTH-1)) ? '0 : st_reg.rd_ptr + 1'b1;
      end
      st_next.count = st_reg.count + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
      if (push) begin
         store[st_reg.wr_ptr] <= in_data;
      end
   end
endmodule

module dbs_host #(
   parameter int DATA_W = dbs_pkg::DATA_W_DEF,
   parameter int ADDR_W = dbs_pkg::ADDR_W_DEF
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   dbs_if.host                    link,
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire logic              cmd_write,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [DATA_W-1:0] cmd_wdata0,
   input  wire logic [DATA_W-1:0] cmd_wdata1,
   input  wire logic [DATA_W/9-1:0] cmd_sel0_n,
   input  wire logic [DATA_W/9-1:0] cmd_sel1_n,
   output logic                   rd_valid,
   input  wire logic              rd_ready,
   output logic [2*DATA_W-1:0]    rd_data
);
   localparam int LANES = DATA_W / dbs_pkg::LANE_W;

   typedef struct packed {
      dbs_pkg::dbs_host_state_t fsm;
      logic                     k;
      logic                     load_n;
      logic                     rnw;
      logic [ADDR_W-1:0]        addr;
      logic [LANES-1:0]         sel_n;
      logic [DATA_W-1:0]        dq_out;
      logic                     dq_oe;
      logic [DATA_W-1:0]        wdata1;
      logic [LANES-1:0]         sel1_n;
      logic [DATA_W-1:0]        word0;
      logic                     push;
   } dbs_host_reg_t;

   dbs_host_reg_t st_reg;
   dbs_host_reg_t st_next;
   logic fifo_in_ready;

   // Issue only ahead of a K edge; a read also needs FIFO room
   assign cmd_ready = ce && st_reg.fsm == dbs_pkg::DBS_IDLE && !st_reg.k &&
                      (cmd_write || fifo_in_ready);

   always_comb begin
      st_next = st_reg;
      if (ce) begin
         st_next.k      = !st_reg.k;
         st_next.load_n = 1'b1;
         st_next.push   = 1'b0;
         case (st_reg.fsm)
            dbs_pkg::DBS_IDLE: begin
               st_next.dq_oe = 1'b0;
               st_next.sel_n = '1;
               if (cmd_valid && cmd_ready) begin
                  st_next.load_n = 1'b0;
                  st_next.rnw    = !cmd_write;
                  st_next.addr   = cmd_addr;
                  if (cmd_write) begin
                     st_next.dq_out = cmd_wdata0;
                     st_next.sel_n  = cmd_sel0_n;
                     st_next.dq_oe  = 1'b1;
                     st_next.wdata1 = cmd_wdata1;
                     st_next.sel1_n = cmd_sel1_n;
                     st_next.fsm    = dbs_pkg::DBS_WR_HI;
                  end else begin
                     st_next.fsm = dbs_pkg::DBS_RD_W0;
                  end
               end
            end
            dbs_pkg::DBS_WR_HI: begin
               st_next.dq_out = st_reg.wdata1;
               st_next.sel_n  = st_reg.sel1_n;
               st_next.fsm    = dbs_pkg::DBS_WR_END;
            end
            dbs_pkg::DBS_WR_END: begin
               // Release before the next K edge so a read can follow
               st_next.dq_oe = 1'b0;
               st_next.sel_n = '1;
               st_next.fsm   = dbs_pkg::DBS_IDLE;
            end
            dbs_pkg::DBS_RD_W0: begin
               // Echo lags K by one cycle, so word0 stands while its inverse is high
               if (link.output_valid_flag && link.echo_clock_n) begin
                  st_next.word0 = link.dq;
                  st_next.fsm   = dbs_pkg::DBS_RD_W1;
               end
            end
            dbs_pkg::DBS_RD_W1: begin
               st_next.push = 1'b1;
               st_next.fsm  = dbs_pkg::DBS_IDLE;
            end
            default: begin
               st_next.fsm = dbs_pkg::DBS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg        <= '0;
         st_reg.fsm    <= dbs_pkg::DBS_IDLE;
         st_reg.k      <= dbs_pkg::RST_K;
         st_reg.load_n <= dbs_pkg::RST_LOAD_N;
         st_reg.sel_n  <= '1;
         st_reg.dq_oe  <= dbs_pkg::RST_OE;
      end else begin
         st_reg <= st_next;
      end
   end

   // Second word is sampled live in the RD_W1 cycle and pushed a cycle later
   logic [DATA_W-1:0] word1_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         word1_reg <= '0;
      end else if (ce && st_reg.fsm == dbs_pkg::DBS_RD_W1) begin
         word1_reg <= link.dq;
      end
   end

   dbs_fifo #(
      .WIDTH (2*DATA_W),
      .DEPTH (dbs_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .in_valid  (st_reg.push),
      .in_ready  (fifo_in_ready),
      .in_data   ({word1_reg, st_reg.word0}),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );

   assign link.k                   = st_reg.k;
   assign link.k_n                 = !st_reg.k;
   assign link.load_strobe_n       = st_reg.load_n;
   assign link.read_not_write      = st_reg.rnw;
   assign link.addr                = st_reg.addr;
   assign link.lane_write_select_n = st_reg.sel_n;
   assign link.host_dq_out         = st_reg.dq_out;
   assign link.host_dq_oe          = st_reg.dq_oe;
endmodule

// ==== hdl/dbs_pkg.sv ====
// Shared constants, types and state encodings of the two-word burst SRAM port
package dbs_pkg;
   localparam int DATA_W_DEF = 18;
   localparam int ADDR_W_DEF = 20;
   localparam int LANE_W     = 9;
   localparam int BURST_LEN  = 2;
   localparam int FIFO_DEPTH = 8;
   localparam int CLK_PERIOD_NS = 20;
   // K rises in one system cycle and the negative clock in the next
   localparam int K_PERIOD_CYCLES = 2;
   // Cycles from the load edge to the first read word on the pins
   localparam int READ_LATENCY_CYCLES = 2;

   localparam logic RST_LOAD_N = 1'b1;
   localparam logic RST_OE     = 1'b0;
   localparam logic RST_VALID  = 1'b0;
   localparam logic RST_K      = 1'b0;

   typedef enum logic [2:0] {
      DBS_IDLE   = 3'b000,
      DBS_WR_HI  = 3'b001,
      DBS_WR_END = 3'b010,
      DBS_RD_W0  = 3'b011,
      DBS_RD_W1  = 3'b100
   } dbs_host_state_t;
endpackage

// ==== hdl/dbs_if.sv ====
// Link between the memory controller end and the burst SRAM end
`timescale 1ns/1ps
interface dbs_if #(
   parameter int DATA_W = dbs_pkg::DATA_W_DEF,
   parameter int ADDR_W = dbs_pkg::ADDR_W_DEF
);
   localparam int LANES = DATA_W / dbs_pkg::LANE_W;

   logic              k;
   logic              k_n;
   logic              load_strobe_n;
   logic              read_not_write;
   logic [ADDR_W-1:0] addr;
   logic [LANES-1:0]  lane_write_select_n;
   logic [DATA_W-1:0] host_dq_out;
   logic              host_dq_oe;
   logic [DATA_W-1:0] dev_dq_out;
   logic              dev_dq_oe;
   logic [DATA_W-1:0] dq;
   logic              echo_clock;
   logic              echo_clock_n;
   logic              output_valid_flag;

   // Shared data wire; an undriven bus reads as zero here
   assign dq = dev_dq_oe ? dev_dq_out : (host_dq_oe ? host_dq_out : '0);

   modport host (
      output k, k_n, load_strobe_n, read_not_write, addr, lane_write_select_n,
      output host_dq_out, host_dq_oe,
      input  dq, echo_clock, echo_clock_n, output_valid_flag
   );
   modport dev (
      input  k, k_n, load_strobe_n, read_not_write, addr, lane_write_select_n,
      input  dq,
      output dev_dq_out, dev_dq_oe, echo_clock, echo_clock_n, output_valid_flag
   );
endinterface

// ==== hdl/dbs_device.sv ====
// Burst SRAM end: two storage arrays, write capture and read launch
//
// Operation
// - Write data captured on both clock edges
// - Read words launched on both clock edges
// - Data drivers released when no read
// - Load strobe sampled only on K edge
// - Every access moves exactly two words
// - Lane selects sampled with their word
// - Each select governs one nine-bit lane
// - Deselected lane keeps stored byte unchanged
// - Address captured on the K edge
// - One address bus serves both directions
// - Storage is two arrays of words
// - Select high reads, low writes
// - Accesses begin only on K edge
// - Valid flag marks read data on pins
`timescale 1ns/1ps
module dbs_device #(
   parameter int DATA_W = dbs_pkg::DATA_W_DEF,
   parameter int ADDR_W = dbs_pkg::ADDR_W_DEF
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   dbs_if.dev        link,
   output logic      busy
);
   localparam int LANES = DATA_W / dbs_pkg::LANE_W;
   localparam int DEPTH = 2 ** ADDR_W;

   typedef struct packed {
      logic              rd_pend;
      logic [ADDR_W-1:0] rd_addr;
      logic              rd_second;
      logic [ADDR_W-1:0] out_addr;
      logic              wr_pend;
      logic [ADDR_W-1:0] wr_addr;
      logic [DATA_W-1:0] dq_out;
      logic              dq_oe;
      logic              valid;
      logic              echo;
   } dbs_dev_state_t;

   dbs_dev_state_t st_reg;
   dbs_dev_state_t st_next;

   // Two arrays: first-word array and second-word array
   logic [DATA_W-1:0] mem_first  [DEPTH];
   logic [DATA_W-1:0] mem_second [DEPTH];

   logic              k_edge;
   logic              kn_edge;
   logic              load_now;
   logic              wr_first;
   logic              wr_second;
   logic [DATA_W-1:0] merged_first;
   logic [DATA_W-1:0] merged_second;

   // Keeps each lane whose active-low select is high
   function automatic logic [DATA_W-1:0] lane_merge(
      input logic [DATA_W-1:0] old_word,
      input logic [DATA_W-1:0] new_word,
      input logic [LANES-1:0]  sel_n
   );
      logic [DATA_W-1:0] res;
      res = old_word;
      for (int i = 0; i < LANES; i++) begin
         if (!sel_n[i]) begin
            res[i*dbs_pkg::LANE_W +: dbs_pkg::LANE_W] =
               new_word[i*dbs_pkg::LANE_W +: dbs_pkg::LANE_W];
         end
      end
      return res;
   endfunction

   // The K edge is the cycle in which the link clock is high
   assign k_edge   = ce && link.k;
   assign kn_edge  = ce && link.k_n;
   // The strobe is looked at on the K edge and never on the other one
   assign load_now = k_edge && !link.load_strobe_n;
   assign wr_first = load_now && !link.read_not_write;
   assign wr_second = kn_edge && st_reg.wr_pend;

   assign merged_first  = lane_merge(mem_first[link.addr], link.dq,
                                     link.lane_write_select_n);
   assign merged_second = lane_merge(mem_second[st_reg.wr_addr], link.dq,
                                     link.lane_write_select_n);

   always_comb begin
      st_next = st_reg;
      if (ce) begin
         st_next.echo = link.k;
      end
      if (k_edge) begin
         st_next.wr_pend = 1'b0;
         if (load_now) begin
            // Same address pins for either direction
            if (link.read_not_write) begin
               st_next.rd_pend = 1'b1;
               st_next.rd_addr = link.addr;
            end else begin
               st_next.wr_pend = 1'b1;
               st_next.wr_addr = link.addr;
            end
         end
         // Second read word leaves on the K edge after the first
         if (st_reg.rd_second) begin
            st_next.dq_out    = mem_second[st_reg.out_addr];
            st_next.rd_second = 1'b0;
         end
      end
      if (kn_edge) begin
         if (st_reg.rd_pend) begin
            // First word goes out registered, showing on the next K edge
            st_next.dq_out    = mem_first[st_reg.rd_addr];
            st_next.out_addr  = st_reg.rd_addr;
            st_next.dq_oe     = 1'b1;
            st_next.valid     = 1'b1;
            st_next.rd_second = 1'b1;
            st_next.rd_pend   = 1'b0;
         end else begin
            // Nothing left to read: let go of the bus by itself
            st_next.dq_oe = 1'b0;
            st_next.valid = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg           <= '0;
         st_reg.dq_oe     <= dbs_pkg::RST_OE;
         st_reg.valid     <= dbs_pkg::RST_VALID;
         st_reg.echo      <= dbs_pkg::RST_K;
      end else begin
         st_reg <= st_next;
      end
   end

   // Storage has no reset; contents after power-up are undefined
   always_ff @(posedge clk) begin
      if (wr_first) begin
         mem_first[link.addr] <= merged_first;
      end
      if (wr_second) begin
         mem_second[st_reg.wr_addr] <= merged_second;
      end
   end

   assign link.dev_dq_out        = st_reg.dq_out;
   assign link.dev_dq_oe         = st_reg.dq_oe;
   assign link.output_valid_flag = st_reg.valid;
   // Echo clocks follow K so read data is edge aligned with them
   assign link.echo_clock        = st_reg.echo;
   assign link.echo_clock_n      = !st_reg.echo;
   assign busy = st_reg.rd_pend || st_reg.rd_second || st_reg.wr_pend || st_reg.dq_oe;
endmodule

// ==== testbench/dbs_checker.sv ====
// Link-side assertions for the two-word burst SRAM port
`timescale 1ns/1ps
module dbs_checker #(
   parameter int DATA_W = 18,
   parameter int ADDR_W = 20
) (
   input wire logic                         clk,
   input wire logic                         rst,
   input wire logic                         ce,
   input wire logic                         k,
   input wire logic                         k_n,
   input wire logic                         load_strobe_n,
   input wire logic                         read_not_write,
   input wire logic [DATA_W/9-1:0]          lane_write_select_n,
   input wire logic                         host_dq_oe,
   input wire logic                         dev_dq_oe,
   input wire logic                         echo_clock,
   input wire logic                         output_valid_flag
);
   default clocking cb @(posedge clk);
   endclocking
   // A stall freezes both ends, so no cycle count holds across it
   default disable iff (rst || !ce);

   a_load_on_k: assert property (!load_strobe_n |-> k)
      else $error("load strobe low outside a K cycle");
   a_read_two_words: assert property ((k && !load_strobe_n && read_not_write) |->
      ##2 (dev_dq_oe && output_valid_flag)[*2])
      else $error("read burst not driven two cycles after load");
   a_release_no_read: assert property (dev_dq_oe |->
      ($past(k && !load_strobe_n && read_not_write, 2) ||
       $past(k && !load_strobe_n && read_not_write, 3)))
      else $error("device drives bus with no read pending");
   a_valid_with_data: assert property (output_valid_flag == dev_dq_oe)
      else $error("valid flag differs from device drive");
   a_no_contention: assert property (!(host_dq_oe && dev_dq_oe))
      else $error("both ends drive the data bus");
   a_write_two_words: assert property ((k && !load_strobe_n && !read_not_write) |->
      host_dq_oe ##1 (host_dq_oe && k_n))
      else $error("write burst not two words on K then negative clock");
   a_k_alternates: assert property (k |=> (!k && k_n))
      else $error("clock phases do not alternate");
   a_echo_follows: assert property (k |=> echo_clock)
      else $error("echo clock does not follow K");
   a_sel_idle_high: assert property (!host_dq_oe |-> (&lane_write_select_n))
      else $error("lane select active with no write data");

   c_write: cover property (k && !load_strobe_n && !read_not_write);
   c_read: cover property (k && !load_strobe_n && read_not_write);
   c_burst: cover property (dev_dq_oe ##1 dev_dq_oe);
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench: controller end and SRAM end joined by the link
`timescale 1ns/1ps
module tb;
   `define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, e); end end

   logic        clk = 1'b0;
   localparam int DW = 18;
   localparam int AW = 6;

   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        busy;
   logic        cmd_valid = 1'b0;
   logic        cmd_ready;
   logic        cmd_write = 1'b0;
   logic [5:0]  cmd_addr = 6'h00;
   logic [17:0] cmd_wdata0 = 18'h00000;
   logic [17:0] cmd_wdata1 = 18'h00000;
   logic [1:0]  cmd_sel0_n = 2'h3;
   logic [1:0]  cmd_sel1_n = 2'h3;
   logic        rd_valid;
   logic        rd_ready = 1'b0;
   logic [35:0] rd_data;
   int          n_errors = 0;
   int          checks = 0;

   always #10 clk = ~clk;

   dbs_if #(.DATA_W(DW), .ADDR_W(AW)) lnk ();
   dbs_host #(.DATA_W(DW), .ADDR_W(AW)) u_dbs_host (
      .clk(clk), .rst(rst), .ce(ce), .link(lnk),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
      .cmd_addr(cmd_addr), .cmd_wdata0(cmd_wdata0), .cmd_wdata1(cmd_wdata1),
      .cmd_sel0_n(cmd_sel0_n), .cmd_sel1_n(cmd_sel1_n),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
   dbs_device #(.DATA_W(DW), .ADDR_W(AW)) u_dbs_device (
      .clk(clk), .rst(rst), .ce(ce), .link(lnk), .busy(busy));
   dbs_checker #(.DATA_W(DW), .ADDR_W(AW)) u_dbs_checker (
      .clk(clk), .rst(rst), .ce(ce), .k(lnk.k), .k_n(lnk.k_n),
      .load_strobe_n(lnk.load_strobe_n), .read_not_write(lnk.read_not_write),
      .lane_write_select_n(lnk.lane_write_select_n), .host_dq_oe(lnk.host_dq_oe),
      .dev_dq_oe(lnk.dev_dq_oe), .echo_clock(lnk.echo_clock),
      .output_valid_flag(lnk.output_valid_flag));

   task automatic give_verdict();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic cmd(input logic w, input logic [5:0] a, input logic [17:0] d0,
                      input logic [17:0] d1, input logic [1:0] s0, input logic [1:0] s1);
      int i;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_addr <= a;
      cmd_wdata0 <= d0;
      cmd_wdata1 <= d1;
      cmd_sel0_n <= s0;
      cmd_sel1_n <= s1;
      @(negedge clk);
      for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge clk);
      `CHK(cmd_ready, 1'b1)
      @(posedge clk);
      cmd_valid <= 1'b0;
   endtask

   // Pop one burst; the read FIFO returns {word1, word0}
   task automatic pop(input logic [35:0] e);
      int i;
      @(negedge clk);
      for (i = 0; i < 50 && rd_valid !== 1'b1; i++) @(negedge clk);
      `CHK(rd_valid, 1'b1)
      `CHK(rd_data, e)
      @(posedge clk);
      rd_ready <= 1'b1;
      @(posedge clk);
      rd_ready <= 1'b0;
   endtask

   task automatic t_write_read();
      cmd(1'b1, 6'h05, 18'h1A2B3, 18'h2C4D5, 2'h0, 2'h0);
      cmd(1'b0, 6'h05, 18'h00000, 18'h00000, 2'h3, 2'h3);
      pop({18'h2C4D5, 18'h1A2B3});
   endtask

   task automatic t_lane_mask();
      // Word0 keeps lane 0, word1 keeps lane 1
      cmd(1'b1, 6'h05, 18'h3FFFF, 18'h3FFFF, 2'h1, 2'h2);
      cmd(1'b0, 6'h05, 18'h00000, 18'h00000, 2'h3, 2'h3);
      pop({18'h2C4D5 | 18'h001FF, 18'h1A2B3 | 18'h3FE00});
   endtask

   task automatic t_arrays_bounds();
      cmd(1'b1, 6'h3F, 18'h12345, 18'h0ABCD, 2'h0, 2'h0);
      cmd(1'b1, 6'h00, 18'h3C3C3, 18'h03C3C, 2'h0, 2'h0);
      cmd(1'b0, 6'h3F, 18'h00000, 18'h00000, 2'h3, 2'h3);
      pop({18'h0ABCD, 18'h12345});
      cmd(1'b0, 6'h00, 18'h00000, 18'h00000, 2'h3, 2'h3);
      pop({18'h03C3C, 18'h3C3C3});
   endtask

   // A stall in the load cycle of a write holds both ends until it ends
   task automatic t_stall();
      cmd(1'b1, 6'h11, 18'h15A5A, 18'h2A5A5, 2'h0, 2'h0);
      ce <= 1'b0;
      repeat (6) @(negedge clk);
      `CHK(busy, 1'b0)
      `CHK(cmd_ready, 1'b0)
      @(posedge clk);
      ce <= 1'b1;
      cmd(1'b0, 6'h11, 18'h00000, 18'h00000, 2'h3, 2'h3);
      @(posedge clk);
      @(negedge clk);
      `CHK(busy, 1'b1)
      pop({18'h2A5A5, 18'h15A5A});
   endtask

   // Eight reads fill the FIFO, a ninth is refused, then all drain in order
   task automatic t_fifo_fill();
      int n;
      for (n = 0; n < 8; n++) begin
         cmd(1'b0, (n[0] ? 6'h3F : 6'h00), 18'h00000, 18'h00000, 2'h3, 2'h3);
      end
      @(posedge clk);
      cmd_valid <= 1'b1;
      repeat (12) @(negedge clk);
      `CHK(cmd_ready, 1'b0)
      @(posedge clk);
      cmd_valid <= 1'b0;
      for (n = 0; n < 8; n++) begin
         pop(n[0] ? {18'h0ABCD, 18'h12345} : {18'h03C3C, 18'h3C3C3});
      end
      @(negedge clk);
      `CHK(rd_valid, 1'b0)
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK(rd_valid, 1'b0)
      t_write_read();
      t_lane_mask();
      t_arrays_bounds();
      t_stall();
      t_fifo_fill();
      `CHK(busy, 1'b0)
      give_verdict();
   end

   // Whole run needs under two hundred cycles; twenty times that means a hang
   initial begin
      repeat (4000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
endmodule
